// >>> logic/occr_defs.svh
`ifndef OCCR_DEFS_SVH
`define OCCR_DEFS_SVH

// Byte addresses in the output configuration space
`define OCCR_ADDR_DRV_DIVTOP 8'h45
`define OCCR_ADDR_SKEW_PAD 8'h47
`define OCCR_ADDR_DIV_UPPER 8'h48
`define OCCR_ADDR_DIV_MIDDLE 8'h49
`define OCCR_ADDR_DIV_LOW 8'h4a
`define OCCR_ADDR_POL_STR 8'h4b

`define OCCR_REG_RESET 8'h00

// Field positions
`define OCCR_DRV_STD_HI 2
`define OCCR_DRV_STD_LO 0
`define OCCR_DIV_TOP_HI 7
`define OCCR_DIV_TOP_LO 6
`define OCCR_SKEW_HI 6
`define OCCR_SKEW_LO 4
`define OCCR_PAD_HI 3
`define OCCR_PAD_LO 0
`define OCCR_DIV_NIB_HI 3
`define OCCR_DIV_NIB_LO 0
`define OCCR_POL_HI 7
`define OCCR_POL_LO 6
`define OCCR_STR_HI 2
`define OCCR_STR_LO 0

// Divider bits that no register of this output holds
`define OCCR_DIV_GAP 12'h000

// Fine skew
`define OCCR_SKEW_STEP_PS 8'h1e
`define OCCR_SKEW_MAX 3'h4

// Recommended single-ended drive strength
`define OCCR_STR_RECOMMENDED 3'h7

// Pad mode codes
`define OCCR_PAD_DIFF_EXT 4'h0
`define OCCR_PAD_DIFF_PD 4'h1
`define OCCR_PAD_DIFF_PU 4'h2
`define OCCR_PAD_SE_POS 4'h4
`define OCCR_PAD_SE_NEG 4'h8
`define OCCR_PAD_SE_BOTH 4'hc

// Polarity codes
`define OCCR_POL_TRUE_COMP 2'h0
`define OCCR_POL_TRUE_BOTH 2'h1

`endif

// >>> logic/occr_pkg.sv
package occr_pkg;

   typedef enum logic [2:0] {
      OCCR_DRV_LVDS,
      OCCR_DRV_LVPECL_CM,
      OCCR_DRV_CML,
      OCCR_DRV_HCSL,
      OCCR_DRV_LVDS_BOOST,
      OCCR_DRV_LVPECL_NOCM,
      OCCR_DRV_RSVD6,
      OCCR_DRV_RSVD7
   } occr_drv_std_type;

   typedef struct packed {
      logic diff_ext_term;
      logic diff_pull_up;
      logic diff_pull_down;
      logic pos_pad_enable;
      logic neg_pad_enable;
      logic mode_invalid;
   } occr_pad_cfg_type;

   // Pad source: 0 is the true phase, 1 the complement phase
   typedef struct packed {
      logic pos_pad_source;
      logic neg_pad_source;
   } occr_pol_type;

   typedef struct packed {
      occr_drv_std_type driver_standard_sel;
      logic [33:0] output_divider;
      logic [2:0] output_skew_code;
      logic [7:0] skew_delay_ps;
      logic skew_code_invalid;
      occr_pad_cfg_type pad;
      occr_pol_type pol;
      logic [2:0] drive_strength;
      logic strength_not_recommended;
   } occr_chan_cfg_type;

endpackage

// >>> logic/occr_regs.sv
`timescale 1ns/1ps
`include "occr_defs.svh"
// Notes on behaviour
// R01: Three low bits of register 45h choose the output driver standard.
// R02: Divider bits 19:0 come from 48h low nibble, 49h and 4Ah.
// R03: Divider bits 33:32 come from bits 7:6 of register 45h.
// R04: Three-bit fine skew code, 0 to 4, delay is code times 30 ps.
// R05: Four-bit pad mode picks differential termination or single-ended pads.
// R06: Two-bit polarity routes true or complement phase to each pad.
// R07: Software should program drive strength to seven; only recommended.
// R08: All fields reset to zero, read back; spare bits store only.
module occr_regs
   import occr_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cfg_wr_en,
   input wire logic cfg_rd_en,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_rd_valid,
   output logic cfg_addr_error,
   output occr_chan_cfg_type chan_cfg
);

   logic [7:0] drv_divtop_r;
   logic [7:0] drv_divtop_nxt;
   logic [7:0] skew_pad_r;
   logic [7:0] skew_pad_nxt;
   logic [7:0] div_upper_r;
   logic [7:0] div_upper_nxt;
   logic [7:0] div_middle_r;
   logic [7:0] div_middle_nxt;
   logic [7:0] div_low_r;
   logic [7:0] div_low_nxt;
   logic [7:0] pol_str_r;
   logic [7:0] pol_str_nxt;

   logic [7:0] cfg_rdata_r;
   logic cfg_rd_valid_r;
   logic cfg_addr_error_r;
   occr_chan_cfg_type chan_cfg_r;
   occr_chan_cfg_type chan_cfg_nxt;

   // True when the address names one of this bank's registers
   function automatic logic addr_mapped(input logic [7:0] a);
      case (a)
         `OCCR_ADDR_DRV_DIVTOP,
         `OCCR_ADDR_SKEW_PAD,
         `OCCR_ADDR_DIV_UPPER,
         `OCCR_ADDR_DIV_MIDDLE,
         `OCCR_ADDR_DIV_LOW,
         `OCCR_ADDR_POL_STR: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction

   // Write strobe for one register address
   function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                   input logic [7:0] target);
      wr_hit = en && (a == target);
   endfunction

   // Fine skew delay in ps; out of range codes are held at the top step
   function automatic logic [7:0] skew_ps(input logic [2:0] code);
      logic [2:0] c;
      logic [10:0] prod;
      c = (code > `OCCR_SKEW_MAX) ? `OCCR_SKEW_MAX : code;
      prod = 11'(c) * 11'(`OCCR_SKEW_STEP_PS);
      skew_ps = prod[7:0];
   endfunction

   // Pad mode decode; unknown codes park both pads off
   function automatic occr_pad_cfg_type pad_decode(input logic [3:0] m);
      occr_pad_cfg_type p;
      p = '0;
      case (m)
         `OCCR_PAD_DIFF_EXT: begin
            p.diff_ext_term = 1'b1;
            p.pos_pad_enable = 1'b1;
            p.neg_pad_enable = 1'b1;
         end
         `OCCR_PAD_DIFF_PU: begin
            p.diff_pull_up = 1'b1;
            p.pos_pad_enable = 1'b1;
            p.neg_pad_enable = 1'b1;
         end
         `OCCR_PAD_DIFF_PD: begin
            p.diff_pull_down = 1'b1;
            p.pos_pad_enable = 1'b1;
            p.neg_pad_enable = 1'b1;
         end
         `OCCR_PAD_SE_POS: begin
            p.pos_pad_enable = 1'b1;
         end
         `OCCR_PAD_SE_NEG: begin
            p.neg_pad_enable = 1'b1;
         end
         `OCCR_PAD_SE_BOTH: begin
            p.pos_pad_enable = 1'b1;
            p.neg_pad_enable = 1'b1;
         end
         default: begin
            p.mode_invalid = 1'b1;
         end
      endcase
      pad_decode = p;
   endfunction

   // Phase routing for the single-ended pads
   function automatic occr_pol_type pol_decode(input logic [1:0] s);
      occr_pol_type p;
      p = '0;
      case (s)
         `OCCR_POL_TRUE_COMP: begin
            p.pos_pad_source = 1'b0;
            p.neg_pad_source = 1'b1;
         end
         `OCCR_POL_TRUE_BOTH: begin
            p.pos_pad_source = 1'b0;
            p.neg_pad_source = 1'b0;
         end
         default: begin
            p.pos_pad_source = 1'b1;
            p.neg_pad_source = 1'b1;
         end
      endcase
      pol_decode = p;
   endfunction

   // Full bytes are stored, spare bits included, so reads return them
   always_comb begin
      drv_divtop_nxt = drv_divtop_r;
      skew_pad_nxt = skew_pad_r;
      div_upper_nxt = div_upper_r;
      div_middle_nxt = div_middle_r;
      div_low_nxt = div_low_r;
      pol_str_nxt = pol_str_r;
      if (wr_hit(cfg_wr_en, cfg_addr, `OCCR_ADDR_DRV_DIVTOP)) begin
         drv_divtop_nxt = cfg_wdata;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, `OCCR_ADDR_SKEW_PAD)) begin
         skew_pad_nxt = cfg_wdata;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, `OCCR_ADDR_DIV_UPPER)) begin
         div_upper_nxt = cfg_wdata;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, `OCCR_ADDR_DIV_MIDDLE)) begin
         div_middle_nxt = cfg_wdata;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, `OCCR_ADDR_DIV_LOW)) begin
         div_low_nxt = cfg_wdata;
      end
      if (wr_hit(cfg_wr_en, cfg_addr, `OCCR_ADDR_POL_STR)) begin
         pol_str_nxt = cfg_wdata;
      end
   end

   // R08: zero reset, hold
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         drv_divtop_r <= `OCCR_REG_RESET;
         skew_pad_r <= `OCCR_REG_RESET;
         div_upper_r <= `OCCR_REG_RESET;
         div_middle_r <= `OCCR_REG_RESET;
         div_low_r <= `OCCR_REG_RESET;
         pol_str_r <= `OCCR_REG_RESET;
      end else begin
         drv_divtop_r <= drv_divtop_nxt;
         skew_pad_r <= skew_pad_nxt;
         div_upper_r <= div_upper_nxt;
         div_middle_r <= div_middle_nxt;
         div_low_r <= div_low_nxt;
         pol_str_r <= pol_str_nxt;
      end
   end

   // Decoded from next values so fields follow a write on the same edge
   always_comb begin
      // R01: driver standard
      chan_cfg_nxt.driver_standard_sel = occr_drv_std_type'(
         drv_divtop_nxt[`OCCR_DRV_STD_HI:`OCCR_DRV_STD_LO]);
      // R03: divider top bits
      // R02: divider low bytes
      chan_cfg_nxt.output_divider = {
         drv_divtop_nxt[`OCCR_DIV_TOP_HI:`OCCR_DIV_TOP_LO],
         `OCCR_DIV_GAP,
         div_upper_nxt[`OCCR_DIV_NIB_HI:`OCCR_DIV_NIB_LO],
         div_middle_nxt,
         div_low_nxt};
      // R04: fine skew delay
      chan_cfg_nxt.output_skew_code =
         skew_pad_nxt[`OCCR_SKEW_HI:`OCCR_SKEW_LO];
      chan_cfg_nxt.skew_delay_ps =
         skew_ps(skew_pad_nxt[`OCCR_SKEW_HI:`OCCR_SKEW_LO]);
      chan_cfg_nxt.skew_code_invalid =
         skew_pad_nxt[`OCCR_SKEW_HI:`OCCR_SKEW_LO] > `OCCR_SKEW_MAX;
      // R05: pad mode decode
      chan_cfg_nxt.pad = pad_decode(skew_pad_nxt[`OCCR_PAD_HI:`OCCR_PAD_LO]);
      // R06: phase routing
      chan_cfg_nxt.pol = pol_decode(pol_str_nxt[`OCCR_POL_HI:`OCCR_POL_LO]);
      chan_cfg_nxt.drive_strength = pol_str_nxt[`OCCR_STR_HI:`OCCR_STR_LO];
      // R07: flag off-advice strength
      chan_cfg_nxt.strength_not_recommended =
         pol_str_nxt[`OCCR_STR_HI:`OCCR_STR_LO] != `OCCR_STR_RECOMMENDED;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         chan_cfg_r <= '0;
      end else begin
         chan_cfg_r <= chan_cfg_nxt;
      end
   end

   // Read port; a read in the cycle of a write returns the old byte
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cfg_rdata_r <= `OCCR_REG_RESET;
         cfg_rd_valid_r <= 1'b0;
      end else begin
         cfg_rd_valid_r <= cfg_rd_en;
         if (cfg_rd_en) begin
            // R08: read back
            case (cfg_addr)
               `OCCR_ADDR_DRV_DIVTOP: cfg_rdata_r <= drv_divtop_r;
               `OCCR_ADDR_SKEW_PAD: cfg_rdata_r <= skew_pad_r;
               `OCCR_ADDR_DIV_UPPER: cfg_rdata_r <= div_upper_r;
               `OCCR_ADDR_DIV_MIDDLE: cfg_rdata_r <= div_middle_r;
               `OCCR_ADDR_DIV_LOW: cfg_rdata_r <= div_low_r;
               `OCCR_ADDR_POL_STR: cfg_rdata_r <= pol_str_r;
               default: cfg_rdata_r <= `OCCR_REG_RESET;
            endcase
         end
      end
   end

   // Unmapped access pulses an error; writes there are dropped
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         cfg_addr_error_r <= 1'b0;
      end else begin
         cfg_addr_error_r <= (cfg_rd_en || cfg_wr_en) &&
                             !addr_mapped(cfg_addr);
      end
   end

   assign cfg_rdata = cfg_rdata_r;
   assign cfg_rd_valid = cfg_rd_valid_r;
   assign cfg_addr_error = cfg_addr_error_r;
   assign chan_cfg = chan_cfg_r;

endmodule

// >>> sim/occr_host.sv
`timescale 1ns/1ps
module occr_host (
   input wire logic clock,
   output logic cfg_wr_en,
   output logic cfg_rd_en,
   output logic [7:0] cfg_addr,
   output logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_addr_error
);
   initial begin
      cfg_wr_en = 1'b0;
      cfg_rd_en = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
   end
   // Released address and data are inverted and the strobes cleared so stale values never look valid
   task xfer(input logic w, input logic [7:0] a, d,
         output logic [7:0] q, output logic e);
      @(posedge clock);
      cfg_wr_en <= w;
      cfg_rd_en <= !w;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clock);
      cfg_wr_en <= 1'b0;
      cfg_rd_en <= 1'b0;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
      #1;
      q = cfg_rdata;
      e = cfg_addr_error;
   endtask
endmodule

// >>> sim/occr_regs_chk.sv
`timescale 1ns/1ps
module occr_regs_chk
   import occr_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic cfg_wr_en,
   input wire logic cfg_rd_en,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_rd_valid,
   input wire logic cfg_addr_error,
   input wire occr_chan_cfg_type chan_cfg
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_rd_valid_pulse: assert property (
      1 |=> cfg_rd_valid == $past(cfg_rd_en)) else $error("bad rd valid");
   a_drv_std_map: assert property (
      cfg_wr_en && cfg_addr == 8'h45 |=> chan_cfg.driver_standard_sel
      == $past(cfg_wdata[2:0])) else $error("bad driver standard");
   a_div_top_bits: assert property (
      cfg_wr_en && cfg_addr == 8'h45 |=> chan_cfg.output_divider[33:32]
      == $past(cfg_wdata[7:6])) else $error("bad divider top");
   a_div_nibble: assert property (
      cfg_wr_en && cfg_addr == 8'h48 |=> chan_cfg.output_divider[19:16]
      == $past(cfg_wdata[3:0])) else $error("bad divider nibble");
   a_div_mid_byte: assert property (
      cfg_wr_en && cfg_addr == 8'h49 |=> chan_cfg.output_divider[15:8]
      == $past(cfg_wdata)) else $error("bad divider middle");
   a_div_low_byte: assert property (
      cfg_wr_en && cfg_addr == 8'h4a |=> chan_cfg.output_divider[7:0]
      == $past(cfg_wdata)) else $error("bad divider low");
   a_skew_delay_ps: assert property (
      chan_cfg.skew_delay_ps == (chan_cfg.output_skew_code > 3'h4 ? 8'h78
      : chan_cfg.output_skew_code * 8'h1e)) else $error("bad skew delay");
   a_pad_pos_only: assert property (
      cfg_wr_en && cfg_addr == 8'h47 && cfg_wdata[3:0] == 4'h4
      |=> chan_cfg.pad.pos_pad_enable && !chan_cfg.pad.neg_pad_enable)
      else $error("bad pad mode");
   a_pol_route: assert property (
      cfg_wr_en && cfg_addr == 8'h4b |=> chan_cfg.pol == {$past(cfg_wdata[7]),
      $past(cfg_wdata[7] | !cfg_wdata[6])}) else $error("bad polarity");
   a_rdata_hold: assert property (
      !cfg_rd_en |=> $stable(cfg_rdata)) else $error("rdata changed");
   c_pol_write: cover property (cfg_wr_en && cfg_addr == 8'h4b);
   c_read: cover property (cfg_rd_valid);
   c_addr_err: cover property (cfg_addr_error);
endmodule
bind occr_regs occr_regs_chk occr_regs_chk_i (.clock(clock),
   .reset_n(reset_n), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
   .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
   .cfg_rd_valid(cfg_rd_valid), .cfg_addr_error(cfg_addr_error),
   .chan_cfg(chan_cfg));

// >>> sim/occr_regs_tb.sv
`timescale 1ns/1ps
module occr_regs_tb;
   import occr_pkg::*;
   logic clock, reset_n, wr, rd, rv, ae, e;
   logic [7:0] ad, wd, rq, q;
   occr_chan_cfg_type cc;
   int n_fail = 0, n_compared = 0, cyc = 0;
   logic [7:0] regs[6] = '{8'h45, 8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b};
   logic [3:0] pc[7] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h8, 4'hc, 4'h3};
   logic [5:0] px[7] = '{6'h26, 6'h16, 6'h0e, 6'h04, 6'h02, 6'h06,
      6'h01};
   logic [1:0] pl[4] = '{2'h1, 2'h0, 2'h3, 2'h3};
   occr_regs occr_regs_i (.clock(clock), .reset_n(reset_n),
      .cfg_wr_en(wr), .cfg_rd_en(rd), .cfg_addr(ad), .cfg_wdata(wd),
      .cfg_rdata(rq), .cfg_rd_valid(rv), .cfg_addr_error(ae),
      .chan_cfg(cc));
   occr_host occr_host_i (.clock(clock), .cfg_wr_en(wr), .cfg_rd_en(rd),
      .cfg_addr(ad), .cfg_wdata(wd), .cfg_rdata(rq), .cfg_addr_error(ae));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         results();
      end
   end
   task chk(input string nm, input logic [33:0] s, x);
      n_compared++;
      if (s !== x) begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, x, s);
      end
   endtask
   task results;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task wrt(input logic [7:0] a, d);
      occr_host_i.xfer(1'b1, a, d, q, e);
   endtask
   task rdchk(input logic [7:0] a, x);
      occr_host_i.xfer(1'b0, a, 8'h00, q, e);
      chk("rdata", q, x);
      chk("rd_valid", rv, 1'b1);
   endtask
   task t_reset;
      for (int i = 0; i < 6; i++) rdchk(regs[i], 8'h00);
      chk("strength flag", cc.strength_not_recommended, 1'b1);
      chk("pad reset", cc.pad, 6'h26);
   endtask
   task t_drv;
      for (int c = 0; c < 8; c++) begin
         wrt(8'h45, {5'h15, c[2:0]});
         chk("drv std", cc.driver_standard_sel, c[2:0]);
         chk("div top", cc.output_divider[33:32], 2'h2);
      end
      rdchk(8'h45, 8'haf);
   endtask
   task t_div;
      wrt(8'h48, 8'ha5);
      wrt(8'h49, 8'hbc);
      wrt(8'h4a, 8'hde);
      chk("wr no err", e, 1'b0);
      chk("divider", cc.output_divider[19:0], 20'h5_bcde);
      chk("divider full", cc.output_divider, 34'h2_0005_bcde);
      rdchk(8'h48, 8'ha5);
      chk("rd no err", e, 1'b0);
      rdchk(8'h49, 8'hbc);
      rdchk(8'h4a, 8'hde);
   endtask
   task t_skew;
      for (int c = 0; c < 8; c++) begin
         wrt(8'h47, {1'b0, c[2:0], 4'h0});
         chk("skew code", cc.output_skew_code, c[2:0]);
         chk("skew ps", cc.skew_delay_ps, 34'((c > 4 ? 4 : c) * 30));
         chk("skew bad", cc.skew_code_invalid, c > 4);
      end
      rdchk(8'h47, 8'h70);
   endtask
   task t_pad;
      for (int i = 0; i < 7; i++) begin
         wrt(8'h47, {4'h3, pc[i]});
         chk("pad", cc.pad, px[i]);
      end
   endtask
   task t_pol;
      for (int c = 0; c < 4; c++) begin
         wrt(8'h4b, {c[1:0], 6'h07});
         chk("pol", cc.pol, pl[c]);
      end
      chk("strength", cc.strength_not_recommended, 1'b0);
      chk("drv strength", cc.drive_strength, 3'h7);
   endtask
   task t_err;
      rdchk(8'h46, 8'h00);
      chk("rd err", e, 1'b1);
      wrt(8'h46, 8'hff);
      chk("wr err", e, 1'b1);
      rdchk(8'h4b, 8'hc7);
   endtask
   initial begin
      reset_n = 1'b0;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      t_reset();
      t_drv();
      t_div();
      t_skew();
      t_pad();
      t_pol();
      t_err();
      results();
   end
endmodule
